// file: rtl/ntrt_params.svh
// constants for the requester id translator
`ifndef NTRT_PARAMS_SVH
`define NTRT_PARAMS_SVH
`define NTRT_OUT_ENTRIES 8
`define NTRT_IN_ENTRIES 32
`define NTRT_ADR_CTRL 8'h00
`define NTRT_ADR_STAT 8'h04
`define NTRT_ADR_MASK 8'h08
`define NTRT_ADR_CAP 8'h0c
`define NTRT_ADR_OUT_BASE 8'h40
`define NTRT_ADR_IN_BASE 8'h80
`define NTRT_ST_OUT_UR 0
`define NTRT_ST_IN_UR 1
`define NTRT_ST_OUT_UNEXP 2
`define NTRT_ST_IN_UNEXP 3
`define NTRT_ST_OUT_OK 4
`define NTRT_ST_IN_OK 5
`define NTRT_ST_W 6
`define NTRT_VBUS_RESET 8'h00
`endif

// file: rtl/ntrt_pkg.sv
// types for the requester id translator
package ntrt_pkg;
   typedef enum logic [1:0]
   {
      NTRT_FWD,
      NTRT_UR,
      NTRT_UNEXP
   } ntrt_verdict_t;
endpackage

// file: rtl/ntrt_translator.sv
// requester and completer id translation for a non-transparent bridge port
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`include "ntrt_params.svh"
module ntrt_translator
(
   input wire logic clk,
   input wire logic resetn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq,
   // config write captures on the two endpoints
   input wire logic link_cap_we,
   input wire logic [12:0] link_cap_bd,
   input wire logic virt_cap_we,
   input wire logic [15:0] virt_cap_bdf,
   // translation request: kind 0 out req,1 out cpl,2 in req,3 in cpl
   input wire logic xl_valid,
   input wire logic [1:0] xl_kind,
   input wire logic [15:0] xl_rid,
   input wire logic [15:0] xl_cid,
   output logic xl_done,
   output logic [1:0] xl_verdict,
   output logic [15:0] xl_rid_out,
   output logic [15:0] xl_cid_out
);
   localparam int NO = `NTRT_OUT_ENTRIES;
   localparam int NI = `NTRT_IN_ENTRIES;
   // entry tables, enable bits cleared by reset
   logic [15:0] out_id [NO];
   logic [NO-1:0] out_en;
   logic [12:0] in_bd [NI];
   logic [NI-1:0] in_en;
   logic [12:0] link_cap;
   logic [15:0] virt_cap;
   logic [7:0] vbus;
   logic [`NTRT_ST_W-1:0] status;
   logic [`NTRT_ST_W-1:0] mask;

   // bus decode
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = bus_req & wb_we_i;
   wire rd = bus_req & ~wb_we_i;
   wire is_out = wb_adr_i[7:5] == 3'b010;
   wire is_in = wb_adr_i[7] == 1'b1;
   wire [2:0] out_sel = wb_adr_i[4:2];
   wire [4:0] in_sel = wb_adr_i[6:2];

   // a write of a full word is needed so a table entry is never half new
   wire full_word = wb_sel_i == 4'hf;

   // lookups
   logic [NO-1:0] out_hit;
   logic [NI-1:0] in_hit;
   genvar g;
   generate
      for (g = 0; g < NO; g++)
      begin : g_out
         assign out_hit[g] = out_en[g] && out_id[g] == xl_rid;
      end
      for (g = 0; g < NI; g++)
      begin : g_in
         assign in_hit[g] = in_en[g] && in_bd[g] == xl_rid[15:3];
      end
   endgenerate

   function automatic logic [4:0] first_hit(input logic [31:0] v);
      logic [4:0] r;
      r = 5'd0;
      for (int i = 31; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   wire [2:0] out_idx = 3'(first_hit({24'h0, out_hit}));
   wire [4:0] in_idx = first_hit(in_hit);
   wire [2:0] cpl_oidx = xl_rid[2:0];
   wire [4:0] cpl_iidx = xl_rid[7:3];
   wire ours = xl_rid[15:3] == link_cap;

   logic [1:0] v_next;
   logic [15:0] rid_next;
   logic [15:0] cid_next;
   logic [`NTRT_ST_W-1:0] ev;
   always_comb
   begin
      v_next = ntrt_pkg::NTRT_FWD;
      rid_next = xl_rid;
      cid_next = xl_cid;
      ev = '0;
      case (xl_kind)
         2'd0:
         begin
            if (|out_hit)
            begin
               rid_next = {link_cap, out_idx};
               ev[`NTRT_ST_OUT_OK] = 1'b1;
            end
            else
            begin
               v_next = ntrt_pkg::NTRT_UR;
               ev[`NTRT_ST_OUT_UR] = 1'b1;
            end
         end
         2'd1:
         begin
            if (ours && out_en[cpl_oidx])
            begin
               rid_next = out_id[cpl_oidx];
               cid_next = virt_cap;
            end
            else
            begin
               v_next = ntrt_pkg::NTRT_UNEXP;
               ev[`NTRT_ST_OUT_UNEXP] = 1'b1;
            end
         end
         2'd2:
         begin
            if (|in_hit)
            begin
               rid_next = {vbus, in_idx, xl_rid[2:0]};
               ev[`NTRT_ST_IN_OK] = 1'b1;
            end
            else
            begin
               v_next = ntrt_pkg::NTRT_UR;
               ev[`NTRT_ST_IN_UR] = 1'b1;
            end
         end
         default:
         begin
            if (in_en[cpl_iidx])
            begin
               rid_next = {in_bd[cpl_iidx], xl_rid[2:0]};
               cid_next = {link_cap, xl_cid[2:0]};
            end
            else
            begin
               v_next = ntrt_pkg::NTRT_UNEXP;
               ev[`NTRT_ST_IN_UNEXP] = 1'b1;
            end
         end
      endcase
      if (!xl_valid)
      begin
         ev = '0;
      end
   end

   // register read mux
   logic [31:0] rd_data;
   always_comb
   begin
      rd_data = 32'h0;
      if (is_out)
      begin
         rd_data = {15'h0, out_en[out_sel], out_id[out_sel]};
      end
      else if (is_in)
      begin
         rd_data = {18'h0, in_en[in_sel], in_bd[in_sel]};
      end
      else
      begin
         case (wb_adr_i)
            `NTRT_ADR_CTRL: rd_data = {24'h0, vbus};
            `NTRT_ADR_STAT: rd_data = {26'h0, status};
            `NTRT_ADR_MASK: rd_data = {26'h0, mask};
            `NTRT_ADR_CAP: rd_data = {3'h0, link_cap, virt_cap};
            default: rd_data = 32'h0;
         endcase
      end
   end

   // status: read clears, but a new event in the same cycle wins
   wire stat_rd = rd && wb_adr_i == `NTRT_ADR_STAT;
   wire [`NTRT_ST_W-1:0] next_status = (stat_rd ? '0 : status) | ev;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         out_en <= '0;
         in_en <= '0;
         vbus <= `NTRT_VBUS_RESET;
         mask <= '0;
         status <= '0;
         link_cap <= 13'h0;
         virt_cap <= 16'h0;
         irq <= 1'b0;
         xl_done <= 1'b0;
         xl_verdict <= 2'd0;
         xl_rid_out <= 16'h0;
         xl_cid_out <= 16'h0;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= rd ? rd_data : 32'h0;
         status <= next_status;
         irq <= |(next_status & mask);
         xl_done <= xl_valid;
         xl_verdict <= v_next;
         xl_rid_out <= rid_next;
         xl_cid_out <= cid_next;
         if (link_cap_we)
         begin
            link_cap <= link_cap_bd;
         end
         if (virt_cap_we)
         begin
            virt_cap <= virt_cap_bdf;
         end
         if (wr && full_word)
         begin
            if (is_out)
            begin
               out_en[out_sel] <= wb_dat_i[16];
            end
            else if (is_in)
            begin
               in_en[in_sel] <= wb_dat_i[13];
            end
            else if (wb_adr_i == `NTRT_ADR_CTRL)
            begin
               vbus <= wb_dat_i[7:0];
            end
            else if (wb_adr_i == `NTRT_ADR_MASK)
            begin
               mask <= wb_dat_i[`NTRT_ST_W-1:0];
            end
         end
      end
   end

   // table identities have no reset; their enables guard them
   always_ff @(posedge clk)
   begin
      if (wr && full_word && is_out)
      begin
         out_id[out_sel] <= wb_dat_i[15:0];
      end
      if (wr && full_word && is_in)
      begin
         in_bd[in_sel] <= wb_dat_i[12:0];
      end
   end
endmodule

// file: testbench/ntrt_assertions.sv
// port assertions for the id translator
`timescale 1ns/100ps
module ntrt_checker
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic link_cap_we,
   input wire logic [12:0] link_cap_bd,
   input wire logic virt_cap_we,
   input wire logic [15:0] virt_cap_bdf,
   input wire logic xl_valid,
   input wire logic [1:0] xl_kind,
   input wire logic [15:0] xl_rid,
   input wire logic [15:0] xl_cid,
   input wire logic xl_done,
   input wire logic [1:0] xl_verdict,
   input wire logic [15:0] xl_rid_out,
   input wire logic [15:0] xl_cid_out
);
   // shadows of the captures and of the request being answered
   logic [12:0] lcap, pl;
   logic [15:0] vcap, pv, pr, pc;
   logic [1:0] pk;
   wire ok = xl_done && xl_verdict == 2'h0;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!resetn);
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         lcap <= 13'h0;
         vcap <= 16'h0;
      end
      else
      begin
         if (link_cap_we)
            lcap <= link_cap_bd;
         if (virt_cap_we)
            vcap <= virt_cap_bdf;
      end
      pl <= lcap;
      pv <= vcap;
      pk <= xl_kind;
      pr <= xl_rid;
      pc <= xl_cid;
   end
   done_next_a: assert property (xl_valid |=> xl_done)
      else $error("done missing");
   done_only_a: assert property (!xl_valid |=> !xl_done)
      else $error("stray done");
   out_busdev_a: assert property
      (ok && pk == 2'h0 |-> xl_rid_out[15:3] == pl) else $error("bad bus");
   cpl_cid_a: assert property
      (ok && pk == 2'h1 |-> xl_cid_out == pv) else $error("bad cid");
   sys_cid_a: assert property
      (ok && pk == 2'h3 |-> xl_cid_out == {pl, pc[2:0]}) else $error("cid");
   in_func_a: assert property
      (ok && pk == 2'h2 |-> xl_rid_out[2:0] == pr[2:0]) else $error("func");
   cpl_owner_a: assert property
      (xl_done && pk == 2'h1 && pr[15:3] != pl |-> xl_verdict == 2'h2)
      else $error("foreign completion taken");
   err_pass_a: assert property
      (xl_done && xl_verdict != 2'h0 |-> xl_rid_out == pr) else $error("id");
endmodule
bind ntrt_translator ntrt_checker i_chk (.clk, .resetn, .link_cap_we,
   .link_cap_bd, .virt_cap_we, .virt_cap_bdf, .xl_valid, .xl_kind, .xl_rid,
   .xl_cid, .xl_done, .xl_verdict, .xl_rid_out, .xl_cid_out);

// file: testbench/ntrt_host_model.sv
// requester side model issuing ids into the translator
`timescale 1ns/100ps
module ntrt_host_model
(
   input wire logic clk,
   output logic xl_valid = 1'b0,
   output logic [1:0] xl_kind = 2'h0,
   output logic [15:0] xl_rid = 16'h0,
   output logic [15:0] xl_cid = 16'h0
);
   // idle id lines toggle so no one leans on a stale value
   task put(input logic v, input logic [1:0] k, input logic [15:0] r, c);
      @(posedge clk);
      xl_valid <= v;
      xl_kind <= k;
      xl_rid <= v ? r : ~xl_rid;
      xl_cid <= v ? c : ~xl_cid;
   endtask
endmodule

// file: testbench/test_ntrt_translator.sv
// self-checking bench for the id translator
`timescale 1ns/100ps
module test_ntrt_translator;
   logic clk, xl_valid, xl_done, wb_ack_o, irq;
   logic resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic link_cap_we = 1'b0, virt_cap_we = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [12:0] link_cap_bd = 13'h0;
   logic [15:0] virt_cap_bdf = 16'h0, xl_rid, xl_cid, xl_rid_out, xl_cid_out;
   logic [1:0] xl_kind, xl_verdict;
   logic [71:0] r;
   int n_errors, total_checks;
   // {address, data}; slot 7 left disabled on purpose
   logic [39:0] cfg [6] = '{40'h00_00000007, 40'h40_00011208,
      40'h4c_00011209, 40'h5c_00001300, 40'h80_00002331, 40'hfc_00002400};
   // {kind, verdict, rid, cid, rid out, cid out}
   logic [71:0] rows [12] = '{72'h00_1208_0000_0918_0000,
      72'h00_1209_0000_091b_0000, 72'h01_1300_0000_1300_0000,
      72'h10_091b_abcd_1209_0208, 72'h10_0918_abcd_1208_0208,
      72'h12_091f_abcd_091f_abcd, 72'h12_0a1b_abcd_0a1b_abcd,
      72'h20_198d_0000_0705_0000, 72'h20_2002_0000_07fa_0000,
      72'h21_3002_0000_3002_0000, 72'h30_07fa_0c0c_2002_091c,
      72'h32_0708_0c0c_0708_0c0c};
   ntrt_host_model i_host (.clk, .xl_valid, .xl_kind, .xl_rid, .xl_cid);
   ntrt_translator i_dut (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq,
      .link_cap_we, .link_cap_bd, .virt_cap_we, .virt_cap_bdf, .xl_valid,
      .xl_kind, .xl_rid, .xl_cid, .xl_done, .xl_verdict, .xl_rid_out,
      .xl_cid_out);
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task check(input logic [31:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ack and read data are taken at the rising edge, then released
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (wb_ack_o === 1'b1)
            break;
      end
      if (i == 20)
      begin
         n_errors++;
         print_verdict;
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      check(q, e);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      link_cap_we <= 1'b1;
      link_cap_bd <= 13'h0123;
      virt_cap_we <= 1'b1;
      virt_cap_bdf <= 16'h0208;
      @(posedge clk);
      link_cap_we <= 1'b0;
      virt_cap_we <= 1'b0;
      for (int i = 0; i < 6; i++)
         wb(1'b1, cfg[i][39:32], cfg[i][31:0]);
      rd(8'h40, 32'h00011208);
      rd(8'h0c, 32'h01230208);
      rd(8'h10, 32'h0);
      // back to back requests, one answer checked per cycle
      for (int i = 0; i <= 12; i++)
      begin
         r = rows[i % 12];
         i_host.put(i < 12, r[69:68], r[63:48], r[47:32]);
         #1;
         r = rows[(i + 11) % 12];
         if (i > 0)
         begin
            check(xl_done, 1'b1);
            check(xl_verdict, r[65:64]);
            check(xl_rid_out, r[31:16]);
            if (r[68])
               check(xl_cid_out, r[15:0]);
         end
      end
      check(irq, 1'b0);
      wb(1'b1, 8'h08, 32'h1);
      repeat (2) @(posedge clk);
      #1 check(irq, 1'b1);
      rd(8'h04, 32'h3f);
      repeat (2) @(posedge clk);
      #1 check(irq, 1'b0);
      rd(8'h04, 32'h0);
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      i_host.put(1'b1, 2'h0, 16'h1208, 16'h0);
      i_host.put(1'b0, 2'h0, 16'h0, 16'h0);
      #1 check(xl_verdict, 2'h1);
      rd(8'h00, 32'h0);
      // a partial write must leave the register alone
      wb_sel_i <= 4'h3;
      wb(1'b1, 8'h00, 32'h55);
      wb_sel_i <= 4'hf;
      rd(8'h00, 32'h0);
      print_verdict;
   end
endmodule
